// ==== pkg/addr_gen_pkg.sv ====
// Shared constants and types for the data and program address generator.
package addr_gen_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the peripheral bus)
  // ----------------------------------------------------------------------
  localparam logic [7:0] addr_mode_control_off = 8'h00;
  localparam logic [7:0] addr_bitrev_control_off = 8'h04;
  localparam logic [7:0] addr_table_page_off = 8'h08;
  localparam logic [7:0] addr_window_page_off = 8'h0c;
  localparam logic [7:0] addr_status_off = 8'h10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] mode_control_rst = 16'h0fff;
  localparam logic [15:0] bitrev_control_rst = 16'h0000;
  localparam logic [7:0] table_page_rst = 8'h00;
  localparam logic [7:0] window_page_rst = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int x_pointer_lsb = 0;
  localparam int y_pointer_lsb = 4;
  localparam int bitrev_pointer_select_lsb = 8;
  localparam int pointer_select_width = 4;
  localparam int y_modulo_enable_bit = 14;
  localparam int x_modulo_enable_bit = 15;
  localparam int bitrev_enable_bit = 15;
  localparam int bitrev_pivot_msb = 14;
  localparam int table_config_bit = 7;
  localparam int window_select_bit = 15;

  // Pointer select value that disables a pointer-based mode.
  localparam logic [3:0] pointer_disabled = 4'hf;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_indirect,
    mode_post_inc,
    mode_post_dec,
    mode_pre_inc,
    mode_pre_dec,
    mode_indexed
  } ea_mode_t;

  typedef enum logic [1:0] {
    access_fetch,
    access_table,
    access_data
  } prog_access_t;

endpackage

// ==== src/addr_gen.sv ====
// Bit-reversed X write addressing and program space address builder.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps

module addr_gen (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // X write address request from the execution path
  input wire logic xw_req,
  input wire logic [3:0] xw_ptr_sel,
  input wire logic [15:0] xw_ptr,
  input wire logic [15:0] xw_offset,
  input wire addr_gen_pkg::ea_mode_t xw_mode,
  input wire logic xw_byte,
  output logic xw_valid,
  output logic [15:0] xw_addr,
  output logic [15:0] xw_ptr_next,
  output logic xw_ptr_write,
  output logic xw_bitrev,
  output logic xw_modulo_en,
  // Modulo permission for the X read unit
  output logic xr_modulo_en,
  // Program space address request
  input wire logic prog_req,
  input wire addr_gen_pkg::prog_access_t prog_kind,
  input wire logic prog_write,
  input wire logic [15:0] prog_ea,
  input wire logic [23:0] prog_counter,
  input wire logic window_enable,
  output logic prog_valid,
  output logic [23:0] prog_addr,
  output logic prog_config_space,
  output logic prog_window,
  output logic prog_low_word_only,
  output logic prog_refused
);

  import addr_gen_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] addressing_mode_control;
  logic [15:0] bitrev_control;
  logic [7:0] table_page;
  logic [7:0] window_page;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire [3:0] x_pointer = addressing_mode_control[x_pointer_lsb +:
                                                 pointer_select_width];
  wire [3:0] bitrev_pointer_select =
    addressing_mode_control[bitrev_pointer_select_lsb +:
                            pointer_select_width];
  wire x_modulo_enable = addressing_mode_control[x_modulo_enable_bit];
  wire bitrev_enable = bitrev_control[bitrev_enable_bit];
  wire [14:0] bitrev_pivot = bitrev_control[bitrev_pivot_msb:0];

  // A pointer-based mode is live only with its enable set and its pointer
  // field off the disable code, so the stack pointer can never take part.
  function automatic logic pointer_mode_on(input logic enable,
                                           input logic [3:0] select);
    pointer_mode_on = enable && (select != pointer_disabled);
  endfunction

  // Modulo in X space needs its pointer field off the disable code.
  wire x_modulo_on = pointer_mode_on(x_modulo_enable, x_pointer);

  // Both conditions must hold before any access is considered.
  wire bitrev_on = pointer_mode_on(bitrev_enable,
                                   bitrev_pointer_select);

  // ----------------------------------------------------------------------
  // X write address generation
  // ----------------------------------------------------------------------
  wire is_incr = (xw_mode == mode_pre_inc) ||
                 (xw_mode == mode_post_inc);
  wire is_pre = (xw_mode == mode_pre_inc) || (xw_mode == mode_pre_dec);
  wire is_post = (xw_mode == mode_post_inc) || (xw_mode == mode_post_dec);
  wire is_indexed = (xw_mode == mode_indexed);

  // Byte accesses and every other mode fall through to normal addressing,
  // and only the write unit ever sees this path.
  wire bitrev_hit = bitrev_on && is_incr && !xw_byte &&
                    (xw_ptr_sel == bitrev_pointer_select);

  wire [15:0] reversed_sum;
  wire [15:0] normal_sum = xw_ptr + xw_offset;

  bitrev_adder u_bitrev_adder (
    .pointer(xw_ptr),
    .pivot(bitrev_pivot),
    .sum(reversed_sum)
  );

  // The pointer steps by the pivot, never by the mode's own offset.
  wire [15:0] bitrev_next = {reversed_sum[15:1], 1'b0};

  wire [15:0] normal_next = (is_pre || is_post) ? normal_sum : xw_ptr;
  wire [15:0] normal_ea = (is_pre || is_indexed) ? normal_sum : xw_ptr;

  // Address bit 0 is ignored and driven low in reversed mode.
  wire [15:0] bitrev_ea = is_pre ? bitrev_next :
                          {xw_ptr[15:1], 1'b0};

  wire [15:0] next_xw_addr = bitrev_hit ? bitrev_ea : normal_ea;
  wire [15:0] next_xw_ptr = bitrev_hit ? bitrev_next : normal_next;
  wire next_xw_ptr_write = bitrev_hit || is_pre || is_post;

  // Reversal wins in the write unit; reads keep modulo as configured.
  wire next_xw_modulo = x_modulo_on && !bitrev_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xw_valid <= 1'b0;
      xw_addr <= 16'h0000;
      xw_ptr_next <= 16'h0000;
      xw_ptr_write <= 1'b0;
      xw_bitrev <= 1'b0;
      xw_modulo_en <= 1'b0;
    end else begin
      xw_valid <= xw_req;
      xw_ptr_write <= xw_req && next_xw_ptr_write;
      if (xw_req) begin
        xw_addr <= next_xw_addr;
        xw_ptr_next <= next_xw_ptr;
        xw_bitrev <= bitrev_hit;
        xw_modulo_en <= next_xw_modulo;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xr_modulo_en <= 1'b0;
    end else begin
      xr_modulo_en <= x_modulo_on;
    end
  end

  // ----------------------------------------------------------------------
  // Program space address construction
  // ----------------------------------------------------------------------
  wire window_hit = (prog_kind == access_data) && window_enable &&
                    prog_ea[window_select_bit];

  wire [23:0] fetch_addr = {1'b0, prog_counter[22:1], 1'b0};
  wire [23:0] table_addr = {table_page, prog_ea};
  // Bit 23 stays low so the window never reaches configuration space,
  // and the page's bit 0 lands on bit 15 in place of the select bit.
  wire [23:0] window_addr = {1'b0, window_page,
                             prog_ea[14:0]};

  wire [23:0] next_prog_addr = (prog_kind == access_fetch) ? fetch_addr :
                               (prog_kind == access_table) ? table_addr :
                               window_addr;

  wire next_prog_valid = prog_req && ((prog_kind == access_fetch) ||
                                      (prog_kind == access_table) ||
                                      (window_hit && !prog_write));
  // A write aimed through the window is dropped and flagged.
  wire next_prog_refused = prog_req && window_hit && prog_write;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_valid <= 1'b0;
      prog_refused <= 1'b0;
      prog_addr <= 24'h000000;
      prog_config_space <= 1'b0;
      prog_window <= 1'b0;
      prog_low_word_only <= 1'b0;
    end else begin
      prog_valid <= next_prog_valid;
      prog_refused <= next_prog_refused;
      if (prog_req) begin
        prog_addr <= next_prog_addr;
        prog_config_space <= (prog_kind == access_table) &&
                             table_page[table_config_bit];
        prog_window <= window_hit;
        prog_low_word_only <= window_hit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Every access completes in one wait-free access phase: pready is
  // raised from the setup cycle, so the answer is registered and stable.
  wire setup_phase = psel && !penable;
  wire write_done = psel && penable && pready && pwrite;

  wire hit_mode = (paddr == addr_mode_control_off);
  wire hit_bitrev = (paddr == addr_bitrev_control_off);
  wire hit_table = (paddr == addr_table_page_off);
  wire hit_window = (paddr == addr_window_page_off);
  wire hit_status = (paddr == addr_status_off);
  wire mapped = hit_mode || hit_bitrev || hit_table || hit_window ||
                hit_status;

  // Status shows live state of the address unit for software.
  wire [31:0] status_word = {13'h0000, bitrev_on, x_modulo_on, xw_bitrev,
                             xw_addr};

  wire [31:0] next_prdata =
    hit_mode ? {16'h0000, addressing_mode_control} :
    hit_bitrev ? {16'h0000, bitrev_control} :
    hit_table ? {24'h000000, table_page} :
    hit_window ? {24'h000000, window_page} :
    hit_status ? status_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
      if (setup_phase && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addressing_mode_control <= mode_control_rst;
      bitrev_control <= bitrev_control_rst;
      table_page <= table_page_rst;
      window_page <= window_page_rst;
    end else if (write_done) begin
      if (hit_mode) begin
        addressing_mode_control <= pwdata[15:0];
      end
      if (hit_bitrev) begin
        bitrev_control <= pwdata[15:0];
      end
      if (hit_table) begin
        table_page <= pwdata[7:0];
      end
      if (hit_window) begin
        window_page <= pwdata[7:0];
      end
    end
  end

endmodule

// ==== src/bitrev_adder.sv ====
// Reverse-carry adder for bit-reversed pointer updates.
`timescale 1ns/10ps

module bitrev_adder (
  input wire logic [15:0] pointer,
  input wire logic [14:0] pivot,
  output logic [15:0] sum
);

  import addr_gen_pkg::*;

  logic [15:0] modifier;
  logic [15:1] carry;

  // Word data only: the pivot counts words, so it moves up one bit.
  assign modifier = {pivot, 1'b0};

  // Carries run from bit 15 toward bit 1, which is the same as adding
  // with both operands mirrored. Bit 0 never takes part.
  always_comb begin
    sum = 16'h0000;
    carry = 15'h0000;
    for (int i = 15; i >= 1; i--) begin
      sum[i] = pointer[i] ^ modifier[i] ^ carry[i];
      if (i > 1) begin
        carry[i-1] = (pointer[i] & modifier[i]) |
                     (carry[i] & (pointer[i] ^ modifier[i]));
      end
    end
  end

endmodule

// ==== verif/addr_gen_monitor.sv ====
// Port-level checks of the address generator.
`timescale 1ns/10ps
module addr_gen_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xw_req,
  input wire addr_gen_pkg::ea_mode_t xw_mode,
  input wire logic xw_byte,
  input wire logic xw_valid,
  input wire logic [15:0] xw_addr,
  input wire logic xw_bitrev,
  input wire logic xw_modulo_en,
  input wire logic prog_req,
  input wire addr_gen_pkg::prog_access_t prog_kind,
  input wire logic prog_write,
  input wire logic [15:0] prog_ea,
  input wire logic window_enable,
  input wire logic prog_valid,
  input wire logic [23:0] prog_addr,
  input wire logic prog_config_space,
  input wire logic prog_window,
  input wire logic prog_refused
);
  import addr_gen_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lsb;
    xw_valid && xw_bitrev |-> !xw_addr[0];
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("odd reversed address");
  property p_byte;
    xw_req && xw_byte |=> xw_valid && !xw_bitrev;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte write reversed");
  property p_mode;
    xw_req && !(xw_mode inside {mode_pre_inc, mode_post_inc}) |=> !xw_bitrev;
  endproperty
  a_mode: assert property (p_mode)
    else $error("wrong mode reversed");
  property p_mod;
    xw_valid && xw_bitrev |-> !xw_modulo_en;
  endproperty
  a_mod: assert property (p_mod)
    else $error("modulo kept with reversal");
  property p_fetch;
    prog_req && prog_kind == access_fetch
      |=> prog_valid && !prog_addr[23] && !prog_addr[0];
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("bad fetch address");
  property p_table;
    prog_req && prog_kind == access_table
      |=> prog_valid && prog_config_space == prog_addr[23];
  endproperty
  a_table: assert property (p_table)
    else $error("space flag wrong");
  property p_win;
    prog_valid && prog_window |-> !prog_addr[23];
  endproperty
  a_win: assert property (p_win)
    else $error("window left user space");
  property p_ro;
    prog_req && prog_write && prog_kind == access_data && prog_ea[15]
      && window_enable |=> prog_refused && !prog_valid;
  endproperty
  a_ro: assert property (p_ro)
    else $error("window write passed");
endmodule

// ==== verif/addr_gen_test.sv ====
// Self-checking bench for the address generator.
`timescale 1ns/10ps
module addr_gen_test;
  import addr_gen_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic xw_req = 0, xw_byte = 0, prog_req = 0, prog_write = 0;
  logic window_enable = 0, ld = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, xw_valid, xw_ptr_write, xw_bitrev;
  logic xw_modulo_en, xr_modulo_en, prog_valid, prog_config_space;
  logic prog_window, prog_low_word_only, prog_refused;
  logic [3:0] xw_ptr_sel = 0;
  logic [15:0] xw_ptr, xw_addr, xw_ptr_next, ld_val = 0;
  logic [15:0] xw_offset = 16'h0002, prog_ea = 0;
  logic [23:0] prog_counter = 0, prog_addr;
  ea_mode_t xw_mode = mode_indirect;
  prog_access_t prog_kind = access_fetch;
  int n_fail = 0, checked = 0;
  addr_gen addr_gen_inst (.*);
  ptr_file ptr_file_inst (.pclk(pclk), .presetn(presetn), .load(ld),
    .load_val(ld_val), .xw_valid(xw_valid), .xw_ptr_write(xw_ptr_write),
    .xw_ptr_next(xw_ptr_next), .ptr(xw_ptr));
  initial forever #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog may end this wait; the slave sets the pace.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic xw(input ea_mode_t m, input logic b, input logic [3:0] s);
    @(posedge pclk);
    xw_req <= 1;
    xw_mode <= m;
    xw_byte <= b;
    xw_ptr_sel <= s;
    @(posedge pclk);
    xw_req <= 0;
    @(negedge pclk);
    chk(xw_valid, 1);
  endtask
  task automatic ldp(input logic [15:0] v);
    @(posedge pclk);
    ld <= 1;
    ld_val <= v;
    @(posedge pclk);
    ld <= 0;
  endtask
  // Normal write from pointer 0x0100 with an offset of two, handed over
  // already negated for the decrement modes as the execution path does.
  task automatic nx(input ea_mode_t m, input logic b, input logic [3:0] s,
    input logic [15:0] a, input logic [1:0] f);
    ldp(16'h0100);
    xw_offset <= (m inside {mode_pre_dec, mode_post_dec}) ? 16'hfffe :
                 16'h0002;
    xw(m, b, s);
    chk(xw_addr, a);
    chk({xw_bitrev, xw_ptr_write}, f);
  endtask
  task automatic pg(input prog_access_t k, input logic w,
    input logic [15:0] ea);
    @(posedge pclk);
    prog_req <= 1;
    prog_kind <= k;
    prog_write <= w;
    prog_ea <= ea;
    @(posedge pclk);
    prog_req <= 0;
    @(negedge pclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, addr_mode_control_off, 0);
    chk(rd, 32'h0fff);
    apb(0, addr_bitrev_control_off, 0);
    chk(rd, 0);
    apb(0, 8'h14, 0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, addr_table_page_off, 32'h85);
    chk(er, 0);
    apb(1, addr_window_page_off, 32'h03);
    apb(0, addr_table_page_off, 0);
    chk(rd, 32'h85);
    prog_counter <= 24'hffffff;
    pg(access_fetch, 0, 0);
    chk(prog_addr, 24'h7ffffe);
    pg(access_table, 0, 16'h1234);
    chk({prog_config_space, prog_addr}, 25'h1851234);
    window_enable <= 1;
    pg(access_data, 0, 16'h8abc);
    chk(prog_addr, 24'h018abc);
    chk({prog_valid, prog_low_word_only, prog_window}, 3'b111);
    pg(access_data, 1, 16'h8abc);
    chk({prog_refused, prog_valid, prog_window}, 3'b101);
    pg(access_data, 0, 16'h0abc);
    chk({prog_refused, prog_valid, prog_window}, 3'b000);
    // Modulo is left on for the same pointer to see which unit wins.
    apb(1, addr_mode_control_off, 32'h8202);
    apb(1, addr_bitrev_control_off, 32'h8008);
    ldp(0);
    for (int i = 0; i < 16; i++) begin
      xw(mode_post_inc, 0, 2);
      chk(xw_addr, {i[0], i[1], i[2], i[3], 1'b0});
      chk({xw_bitrev, xw_modulo_en, xr_modulo_en}, 3'b101);
    end
    ldp(0);
    xw(mode_pre_inc, 0, 2);
    chk({xw_addr, xw_ptr_next}, 32'h00100010);
    apb(0, addr_status_off, 0);
    chk(rd, 32'h00070010);
    nx(mode_post_inc, 1, 2, 16'h0100, 2'b01);
    nx(mode_pre_dec, 0, 2, 16'h00fe, 2'b01);
    nx(mode_indexed, 0, 2, 16'h0102, 2'b00);
    nx(mode_post_inc, 0, 3, 16'h0100, 2'b01);
    apb(1, addr_bitrev_control_off, 32'h0008);
    nx(mode_post_inc, 0, 2, 16'h0100, 2'b01);
    apb(1, addr_mode_control_off, 32'h8f02);
    apb(1, addr_bitrev_control_off, 32'h8008);
    nx(mode_post_inc, 0, 15, 16'h0100, 2'b01);
    end_of_test;
  end
endmodule
bind addr_gen addr_gen_monitor addr_gen_monitor_inst (.*);

// ==== verif/ptr_file.sv ====
// Pointer register of the execution path feeding the X write unit.
`timescale 1ns/10ps
module ptr_file (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic xw_valid,
  input wire logic xw_ptr_write,
  input wire logic [15:0] xw_ptr_next,
  output logic [15:0] ptr
);
  // Write-back only on request, so a stray pulse cannot corrupt the walk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ptr <= '0;
    else if (load)
      ptr <= load_val;
    else if (xw_valid && xw_ptr_write)
      ptr <= xw_ptr_next;
  end
endmodule
